// file: csss_top.sv
// clock stop control and startup sequencer with status register
`timescale 1ns/100ps
module csss_top import csss_pkg::*; #(
  parameter int BIAS_TMO_CYC = CSSS_BIAS_TMO_CYC,
  parameter int OTP_TMO_CYC = CSSS_OTP_TMO_CYC,
  parameter int APLL_TMO_CYC = CSSS_APLL_TMO_CYC,
  parameter int SYSDIV_WAIT_CYC = CSSS_SYSDIV_WAIT_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_ack,
  output logic o_digital_domain_clock_stop,
  output logic o_signal_monitor_clock_stop,
  input wire logic i_sysdiv_toggling,
  output logic o_ring_osc_sel,
  output logic o_bias_cal_start,
  input wire logic i_bias_cal_done,
  output logic o_otp_load_req,
  output logic o_otp_load_user,
  output logic [1:0] o_otp_user_idx,
  input wire logic i_otp_load_done,
  output logic o_apll_start,
  input wire logic i_apll_lock
);
  csss_state_t state_q;
  csss_state_t state_d;
  logic [15:0] clk_stop_q;
  logic [3:0] cfg_sel_q;
  logic [2:0] flags_q;
  logic fallback_q;
  logic ready_q;
  logic [1:0] loaded_q;
  logic [15:0] rdata_q;
  logic ack_q;
  logic clk_tmo;
  logic bias_tmo;
  logic otp_tmo;
  logic apll_tmo;

  // =====================================================
  // register access decode
  wire frozen = clk_stop_q[CSSS_DIG_STOP_BIT];
  wire wr_ok = i_reg_wr && !frozen;
  wire rd_ok = i_reg_rd && !frozen;
  wire wr_stop = wr_ok && (i_reg_addr == CSSS_ADDR_CLK_STOP);
  wire wr_cfg = wr_ok && (i_reg_addr == CSSS_ADDR_CFG_SEL);
  wire [7:0] status_word = {flags_q, fallback_q, ready_q, 1'b0, loaded_q};
  wire [15:0] rd_mux;
  assign rd_mux = (i_reg_addr == CSSS_ADDR_CLK_STOP) ? clk_stop_q :
                  (i_reg_addr == CSSS_ADDR_STATUS) ? {8'h00, status_word} :
                  (i_reg_addr == CSSS_ADDR_CFG_SEL) ? {12'h000, cfg_sel_q} : 16'h0000;
  wire [15:0] stop_d = (i_reg_wdata & CSSS_CLK_STOP_RW_MASK) | (clk_stop_q & ~CSSS_CLK_STOP_RW_MASK);

  // only stored bits are writable; read-only reserved bits stay zero
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clk_stop_q <= CSSS_CLK_STOP_RST;
      cfg_sel_q <= CSSS_CFG_SEL_RST;
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_stop) begin
        clk_stop_q <= stop_d;
      end
      if (wr_cfg) begin
        cfg_sel_q <= i_reg_wdata[3:0];
      end
      if (rd_ok) begin
        rdata_q <= rd_mux;
      end
      ack_q <= wr_ok || rd_ok;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_reg_ack = ack_q;
  // stop bits 11 and 3 drive the block clock gates directly; only digital stop bit 11 has no way back but reset
  assign o_digital_domain_clock_stop = clk_stop_q[CSSS_DIG_STOP_BIT];
  assign o_signal_monitor_clock_stop = clk_stop_q[CSSS_MON_STOP_BIT];

  // =====================================================
  // phase timeouts
  csss_timeout #(.LIMIT(SYSDIV_WAIT_CYC)) u_clk_tmo (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en),
    .i_run(state_q == ST_CLK_CHECK), .o_expired(clk_tmo));
  csss_timeout #(.LIMIT(BIAS_TMO_CYC)) u_bias_tmo (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en),
    .i_run(state_q == ST_BIAS_CAL), .o_expired(bias_tmo));
  csss_timeout #(.LIMIT(OTP_TMO_CYC)) u_otp_tmo (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en),
    .i_run(state_q == ST_OTP_COMMON || state_q == ST_OTP_USER), .o_expired(otp_tmo));
  csss_timeout #(.LIMIT(APLL_TMO_CYC)) u_apll_tmo (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en),
    .i_run(state_q == ST_APLL_LOCK), .o_expired(apll_tmo));

  // =====================================================
  // startup sequencer
  wire user_valid = (cfg_sel_q <= CSSS_CFG_SEL_USER_MAX); // out-of-range select loads common only
  wire [1:0] user_idx = cfg_sel_q[1:0];

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_CLK_CHECK: begin
        if (i_sysdiv_toggling || clk_tmo) state_d = ST_BIAS_CAL;
      end
      ST_BIAS_CAL: begin
        if (i_bias_cal_done || bias_tmo) state_d = ST_OTP_COMMON;
      end
      ST_OTP_COMMON: begin
        if (otp_tmo) state_d = ST_APLL_LOCK;
        else if (i_otp_load_done) state_d = user_valid ? ST_OTP_USER : ST_APLL_LOCK;
      end
      ST_OTP_USER: begin
        if (i_otp_load_done || otp_tmo) state_d = ST_APLL_LOCK;
      end
      ST_APLL_LOCK: begin
        if (i_apll_lock || apll_tmo) state_d = ST_DONE;
      end
      default: state_d = ST_DONE;
    endcase
  end

  // status only moves while the sequence runs; done state never writes it
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ST_CLK_CHECK;
      flags_q <= 3'h0;
      fallback_q <= 1'b0;
      ready_q <= 1'b0;
      loaded_q <= 2'h0;
    end else if (i_clk_en) begin
      state_q <= state_d;
      if (state_q == ST_CLK_CHECK && !i_sysdiv_toggling && clk_tmo) begin
        fallback_q <= 1'b1;
      end
      if (state_q == ST_BIAS_CAL && !i_bias_cal_done && bias_tmo) begin
        flags_q[CSSS_FLAG_BIAS] <= 1'b1;
      end
      if ((state_q == ST_OTP_COMMON || state_q == ST_OTP_USER) && otp_tmo) begin
        flags_q[CSSS_FLAG_OTP] <= 1'b1;
      end
      if (state_q == ST_APLL_LOCK && !i_apll_lock && apll_tmo) begin
        flags_q[CSSS_FLAG_APLL] <= 1'b1;
      end
      if (!otp_tmo && i_otp_load_done &&
          (state_q == ST_OTP_USER || (state_q == ST_OTP_COMMON && !user_valid))) begin
        ready_q <= 1'b1;
      end
      if (!otp_tmo && i_otp_load_done && state_q == ST_OTP_USER) begin
        loaded_q <= user_idx;
      end
    end
  end

  // handshake levels to the analog and memory helpers
  assign o_ring_osc_sel = fallback_q;
  assign o_bias_cal_start = (state_q == ST_BIAS_CAL);
  assign o_otp_load_req = (state_q == ST_OTP_COMMON || state_q == ST_OTP_USER);
  assign o_otp_load_user = (state_q == ST_OTP_USER);
  assign o_otp_user_idx = user_idx;
  assign o_apll_start = (state_q == ST_APLL_LOCK);

  // =====================================================
  // checks
  chk_stop_needs_write: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(o_signal_monitor_clock_stop) |-> $past(wr_stop && i_reg_wdata[CSSS_MON_STOP_BIT]))
    else $error("monitor stop rose without a write");
  chk_dig_stop_sticks: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    o_digital_domain_clock_stop |=> o_digital_domain_clock_stop)
    else $error("digital stop released without reset");
  chk_frozen_no_access: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    o_digital_domain_clock_stop |=> !o_reg_ack && $stable(clk_stop_q) && $stable(o_reg_rdata))
    else $error("register access while digital clocks stopped");
  chk_monitor_stop_write: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    wr_stop && i_clk_en && i_reg_wdata[CSSS_MON_STOP_BIT] |=> o_signal_monitor_clock_stop)
    else $error("monitor stop not applied after write");
  chk_bias_flag_cause: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(flags_q[CSSS_FLAG_BIAS]) |-> $past(state_q == ST_BIAS_CAL && bias_tmo))
    else $error("bias flag without bias timeout");
  chk_otp_flag_cause: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(flags_q[CSSS_FLAG_OTP]) |-> $past(o_otp_load_req && otp_tmo))
    else $error("memory load flag without timeout");
  chk_apll_flag_cause: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(flags_q[CSSS_FLAG_APLL]) |-> $past(state_q == ST_APLL_LOCK && !i_apll_lock && apll_tmo))
    else $error("lock flag while lock reported");
  chk_fallback_cause: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(o_ring_osc_sel) |-> $past(state_q == ST_CLK_CHECK && !i_sysdiv_toggling && clk_tmo))
    else $error("fallback while divider toggled");
  chk_ready_cause: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(ready_q) |-> $past(i_otp_load_done) && state_q == ST_APLL_LOCK)
    else $error("ready without memory load completion");
  chk_user_after_common: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(o_otp_load_user) |-> $past(state_q == ST_OTP_COMMON && i_otp_load_done))
    else $error("user image loaded before common image");
  chk_status_frozen_done: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    state_q == ST_DONE |=> $stable(status_word) ##1 $stable(status_word))
    else $error("status changed after startup");
  chk_stop_reserved_zero: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    (clk_stop_q & ~CSSS_CLK_STOP_RW_MASK) == 16'h0000)
    else $error("read-only clock stop bit became set");
  chk_loaded_from_user: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $changed(loaded_q) |-> $past(state_q == ST_OTP_USER && i_otp_load_done && !otp_tmo))
    else $error("loaded index changed outside user image load");
  chk_common_first: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(o_otp_load_req) |-> !o_otp_load_user)
    else $error("memory load did not start with common image");
  chk_ready_on_load: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    state_q == ST_OTP_USER && i_otp_load_done && !otp_tmo && i_clk_en |=> ready_q)
    else $error("ready not set after user image load");
  // a low enable must hold the sequencer, status and bus answer exactly where they are
  chk_enable_freeze: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
    !i_clk_en |=> $stable(state_q) && $stable(status_word) && $stable(clk_stop_q) && $stable(o_reg_ack))
    else $error("state moved while clock enable low");

  cov_fallback: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n) $rose(o_ring_osc_sel));
  cov_ready_user: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n) $rose(ready_q) && loaded_q != 2'h0);
  cov_apll_tmo: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n) $rose(flags_q[CSSS_FLAG_APLL]));
  cov_dig_stop: cover property (@(posedge i_ref_clk) disable iff (!i_arst_n) $rose(o_digital_domain_clock_stop));
endmodule

// file: csss_pkg.sv
// constants for the clock stop and startup status register bank
//
// Contract
// - a set stop bit halts that block's clocks; zero after reset runs everything. Only bits 11 and 3 reach an output; bits 0, 6, 8 are stored only.
// - digital-domain stop bit 11 gates every digital clock without its own bit.
// - once bit 11 is set, register accesses are ignored until power cycle.
// - stop bit 3 holds the crystal signal monitor without a clock.
// - status flag bit 0 (field 7:5) marks bias calibration not done within 2 ms.
// - status flag bit 1 marks configuration memory load not done within 10 ms.
// - status flag bit 2 marks analog PLL lock not reported within 2 ms.
// - if the divided system clock never toggles, switch to the ring oscillator.
// - status bit 4 shows the ring oscillator was substituted.
// - ready bit 3 is set when the startup memory load completes.
// - status bits 1:0 report the user configuration index that was loaded.
// - the common configuration is always loaded, before any user configuration.
// - the user configuration comes from a four-bit select field, reset value 0x4.
package csss_pkg;
  // =====================================================
  // register map
  localparam logic [7:0] CSSS_ADDR_CLK_STOP = 8'h00;
  localparam logic [7:0] CSSS_ADDR_STATUS = 8'h01;
  localparam logic [7:0] CSSS_ADDR_CFG_SEL = 8'h02;
  localparam int CSSS_DW = 16;

  // =====================================================
  // clock stop register fields
  localparam int CSSS_DIG_STOP_BIT = 11;
  localparam int CSSS_MON_STOP_BIT = 3;
  localparam logic [15:0] CSSS_CLK_STOP_RW_MASK = 16'h0949;
  localparam logic [15:0] CSSS_CLK_STOP_RST = 16'h0000;

  // =====================================================
  // status register fields
  localparam int CSSS_FLAG_LSB = 5;
  localparam int CSSS_FALLBACK_BIT = 4;
  localparam int CSSS_READY_BIT = 3;
  localparam int CSSS_LOADED_LSB = 0;
  localparam int CSSS_FLAG_BIAS = 0;
  localparam int CSSS_FLAG_OTP = 1;
  localparam int CSSS_FLAG_APLL = 2;

  // =====================================================
  // configuration select
  localparam logic [3:0] CSSS_CFG_SEL_RST = 4'h4;
  localparam logic [3:0] CSSS_CFG_SEL_USER_MAX = 4'h3;

  // =====================================================
  // timing
  localparam int CSSS_CLK_MHZ = 250;
  localparam int CSSS_BIAS_TMO_US = 2000;
  localparam int CSSS_OTP_TMO_US = 10000;
  localparam int CSSS_APLL_TMO_US = 2000;
  localparam int CSSS_BIAS_TMO_CYC = CSSS_BIAS_TMO_US * CSSS_CLK_MHZ;
  localparam int CSSS_OTP_TMO_CYC = CSSS_OTP_TMO_US * CSSS_CLK_MHZ;
  localparam int CSSS_APLL_TMO_CYC = CSSS_APLL_TMO_US * CSSS_CLK_MHZ;
  localparam int CSSS_SYSDIV_WAIT_CYC = 256;

  typedef enum logic [2:0] {
    ST_CLK_CHECK,
    ST_BIAS_CAL,
    ST_OTP_COMMON,
    ST_OTP_USER,
    ST_APLL_LOCK,
    ST_DONE
  } csss_state_t;
endpackage

// file: csss_timeout.sv
// phase timeout counter: flags expiry after LIMIT cycles of run
`timescale 1ns/100ps
module csss_timeout #(
  parameter int LIMIT = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic i_run,
  output logic o_expired
);
  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LAST = W'(LIMIT - 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire at_last = (cnt_q == LAST);

  // saturate so a late answer never wraps into a second expiry
  assign cnt_d = !i_run ? '0 : (at_last ? cnt_q : cnt_q + W'(1));
  assign o_expired = i_run && at_last;

  // =====================================================
  // counter
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= '0;
    end else if (i_clk_en) begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// file: csss_bench_top.sv
// self-checking bench for the clock stop and startup status bank
`timescale 1ns/100ps
module clock_stop_and_startup_status_bench;
  import csss_pkg::*;
  logic i_ref_clk = 0, i_arst_n = 0, i_clk_en = 1, i_reg_wr = 0, i_reg_rd = 0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata, rd;
  logic o_reg_ack, o_digital_domain_clock_stop, o_signal_monitor_clock_stop, o_ring_osc_sel;
  logic i_sysdiv_toggling = 0, i_bias_cal_done = 0, i_otp_load_done = 0, i_apll_lock = 0;
  logic o_bias_cal_start, o_otp_load_req, o_otp_load_user, o_apll_start;
  logic [1:0] o_otp_user_idx;
  int fail_count = 0, comparisons = 0, cycles = 0, sel, w;
  bit fast = 0, go = 0;
  int images[$];
  logic [31:0] seed = 32'd51399;

  // =====================================================
  // design, with the long startup counts shortened; clock check wait leaves room for the select write
  csss_top #(.BIAS_TMO_CYC(20), .OTP_TMO_CYC(40), .APLL_TMO_CYC(20), .SYSDIV_WAIT_CYC(16)) dut_u (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_ack(o_reg_ack), .o_digital_domain_clock_stop(o_digital_domain_clock_stop),
    .o_signal_monitor_clock_stop(o_signal_monitor_clock_stop), .i_sysdiv_toggling(i_sysdiv_toggling),
    .o_ring_osc_sel(o_ring_osc_sel), .o_bias_cal_start(o_bias_cal_start), .i_bias_cal_done(i_bias_cal_done),
    .o_otp_load_req(o_otp_load_req), .o_otp_load_user(o_otp_load_user), .o_otp_user_idx(o_otp_user_idx),
    .i_otp_load_done(i_otp_load_done), .o_apll_start(o_apll_start), .i_apll_lock(i_apll_lock));

  // clock and hang guard; the ceiling is far above four startups
  initial begin
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      stop_test();
    end
  end

  // =====================================================
  // far-side responder: prompt when fast, silent otherwise
  always @(negedge i_ref_clk) begin
    i_sysdiv_toggling <= go && fast;
    i_bias_cal_done <= fast && o_bias_cal_start;
    i_apll_lock <= fast && o_apll_start;
    i_otp_load_done <= fast && o_otp_load_req && !i_otp_load_done; // one pulse per image
    if (fast && o_otp_load_req && !i_otp_load_done) begin
      images.push_back(o_otp_load_user ? 4 + int'(o_otp_user_idx) : 0);
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle strobe; ack is due in the following cycle
  task automatic bus(input bit wr, input logic [7:0] a, input logic [15:0] d, input bit ack);
    @(negedge i_ref_clk);
    i_reg_wr = wr;
    i_reg_rd = !wr;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_ref_clk);
    i_reg_wr = 0;
    i_reg_rd = 0;
    check(16'(o_reg_ack), 16'(ack));
    rd = o_reg_rdata;
  endtask

  task automatic do_reset();
    i_arst_n = 0;
    go = 0;
    images = {};
    repeat (6) @(negedge i_ref_clk);
    i_arst_n = 1;
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // =====================================================
  // main sequence
  initial begin
    // silent far side: every timeout and the fallback
    do_reset();
    repeat (120) @(negedge i_ref_clk);
    bus(0, CSSS_ADDR_STATUS, 16'h0000, 1);
    check(rd, 16'h00F0);
    check(16'(o_ring_osc_sel), 16'h0001);
    bus(0, CSSS_ADDR_CLK_STOP, 16'h0000, 1);
    check(rd, 16'h0000);
    w = int'(rnd() & 32'h0000F7F7);
    bus(1, CSSS_ADDR_CLK_STOP, 16'(w), 1);
    bus(0, CSSS_ADDR_CLK_STOP, 16'h0000, 1);
    check(rd, 16'(w) & 16'h0949);
    bus(1, CSSS_ADDR_CLK_STOP, 16'h0008, 1);
    check(16'(o_signal_monitor_clock_stop), 16'h0001);
    check(16'(o_digital_domain_clock_stop), 16'h0000);
    // enable low: an access is neither taken nor answered
    @(negedge i_ref_clk);
    i_clk_en = 0;
    bus(1, CSSS_ADDR_CLK_STOP, 16'h0001, 0);
    i_clk_en = 1;
    bus(0, CSSS_ADDR_CLK_STOP, 16'h0000, 1);
    check(rd, 16'h0008);
    check(16'(o_signal_monitor_clock_stop), 16'h0001);
    bus(0, 8'h55, 16'h0000, 1);
    check(rd, 16'h0000);
    bus(1, CSSS_ADDR_STATUS, 16'hFFFF, 1);
    bus(0, CSSS_ADDR_STATUS, 16'h0000, 1);
    check(rd, 16'h00F0);
    $display("test 0 done");
    // digital stop locks the bus until reset
    bus(1, CSSS_ADDR_CLK_STOP, 16'h0800, 1);
    check(16'(o_digital_domain_clock_stop), 16'h0001);
    bus(0, CSSS_ADDR_CLK_STOP, 16'h0000, 0);
    check(rd, 16'h00F0);
    bus(1, CSSS_ADDR_CLK_STOP, 16'h0000, 0);
    check(16'(o_digital_domain_clock_stop), 16'h0001);
    $display("test 1 done");
    // prompt far side: default, random user and random common-only selections
    fast = 1;
    for (int k = 0; k < 3; k++) begin
      do_reset();
      sel = k == 0 ? 4 : k == 1 ? int'(rnd() % 4) : 4 + int'(rnd() % 12);
      if (k > 0) bus(1, CSSS_ADDR_CFG_SEL, 16'(sel), 1);
      bus(0, CSSS_ADDR_CFG_SEL, 16'h0000, 1);
      check(rd, 16'(sel));
      bus(0, CSSS_ADDR_CLK_STOP, 16'h0000, 1);
      check(rd, 16'h0000);
      go = 1;
      repeat (120) @(negedge i_ref_clk);
      bus(0, CSSS_ADDR_STATUS, 16'h0000, 1);
      check(rd, 16'h0008 | 16'(sel <= 3 ? sel : 0));
      check(16'(o_ring_osc_sel), 16'h0000);
      check(16'({o_bias_cal_start, o_otp_load_req, o_apll_start}), 16'h0000);
      check(16'(images.size()), 16'(sel <= 3 ? 2 : 1));
      check(16'(images[0]), 16'h0000);
      if (sel <= 3) check(16'(images[1]), 16'(4 + sel));
      $display("test %0d done", k + 2);
    end
    stop_test();
  end
endmodule
